// ==== testbench/testbench.sv ====
// Self-checking bench for the up/down timer through its register port and pins
`timescale 1ns/100ps
module testbench;
    localparam int HALF = 2 * (65536 - 16'hfffe);
    logic        mclk;
    logic        rstn;
    logic [7:0]  sfrAddr;
    logic        sfrWr;
    logic [7:0]  sfrWrData;
    logic        sfrRd;
    logic [7:0]  sfrRdData;
    logic        bitWr;
    logic [7:0]  bitAddr;
    logic        bitVal;
    logic        pinLvl;
    logic        pinWire;
    logic        pinOut;
    logic        pinOe;
    logic        extPin;
    logic        t1Ovf;
    logic        rxTick;
    logic        txTick;
    logic        timerIrq;
    logic [15:0] rxCount;
    logic [15:0] txCount;
    logic [15:0] r0;
    logic [15:0] t0;
    int          errors;
    int          n_tests;
    int          h;
    // Pin wire: the timer wins while it drives, else the bench level
    assign pinWire = pinOe ? pinOut : pinLvl;
    ttu_timer i_ttu_timer (.mclk(mclk), .rstn(rstn), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrWrData(sfrWrData),
        .sfrRd(sfrRd), .sfrRdData(sfrRdData), .bitWr(bitWr), .bitAddr(bitAddr), .bitVal(bitVal),
        .countClockPinIn(pinWire), .countClockPinOut(pinOut), .countClockPinOe(pinOe),
        .externalControlPin(extPin), .timerOneOverflow(t1Ovf), .serialRxClockTick(rxTick),
        .serialTxClockTick(txTick), .timerIrq(timerIrq));
    ttu_serial_model i_ttu_serial_model (.mclk(mclk), .rstn(rstn), .rxTick(rxTick), .txTick(txTick),
        .timerOneOverflow(t1Ovf), .rxCount(rxCount), .txCount(txCount));
    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        sfrAddr = a;
        sfrWrData = d;
        sfrWr = 1'b1;
        @(negedge mclk);
        sfrWr = 1'b0;
    endtask
    task automatic bw(input int b, input logic v);
        @(negedge mclk);
        bitAddr = 8'hc8 + 8'(b);
        bitVal = v;
        bitWr = 1'b1;
        @(negedge mclk);
        bitWr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk);
        sfrAddr = a;
        sfrRd = 1'b1;
        @(negedge mclk);
        sfrRd = 1'b0;
        @(negedge mclk);
        chk(sfrRdData, e);
    endtask
    // One falling edge on the count pin (0) or the control pin (1)
    task automatic pulse(input bit which);
        @(negedge mclk);
        if (which) extPin = 1'b0;
        else pinLvl = 1'b0;
        repeat (3) @(negedge mclk);
        if (which) extPin = 1'b1;
        else pinLvl = 1'b1;
        repeat (3) @(negedge mclk);
    endtask
    task automatic waitLvl(input logic v, output int n);
        for (n = 0; n < 100; n++)
        begin
            if (pinOut === v) break;
            @(negedge mclk);
        end
        if (n == 100)
        begin
            errors++;
            $display("MISMATCH t=%0t clock out stuck", $time);
            give_verdict();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial
    begin
        {rstn, sfrWr, sfrRd, bitWr, bitVal} = '0;
        {sfrAddr, sfrWrData, bitAddr} = '0;
        {pinLvl, extPin} = 2'b11;
        errors = 0;
        n_tests = 0;
        repeat (6) @(negedge mclk);
        rstn = 1'b1;
        rd(ttu_pkg::CTL_ADDR, 8'h00);
        rd(ttu_pkg::MODE_ADDR, 8'h00);
        rd(8'hc0, 8'h00);
        wr(ttu_pkg::RELOAD_H_ADDR, 8'ha5);
        rd(ttu_pkg::RELOAD_H_ADDR, 8'ha5);
        // Carry from low into high byte, counter mode
        wr(ttu_pkg::COUNT_H_ADDR, 8'h00);
        wr(ttu_pkg::COUNT_L_ADDR, 8'hff);
        wr(ttu_pkg::CTL_ADDR, 8'h06);
        pulse(0);
        rd(ttu_pkg::COUNT_L_ADDR, 8'h00);
        rd(ttu_pkg::COUNT_H_ADDR, 8'h01);
        bw(ttu_pkg::RUN_BIT, 1'b0);
        pulse(0);
        rd(ttu_pkg::COUNT_L_ADDR, 8'h00);
        // Overflow reload and flag
        wr(ttu_pkg::RELOAD_L_ADDR, 8'h34);
        wr(ttu_pkg::RELOAD_H_ADDR, 8'h12);
        wr(ttu_pkg::COUNT_L_ADDR, 8'hff);
        wr(ttu_pkg::COUNT_H_ADDR, 8'hff);
        bw(ttu_pkg::RUN_BIT, 1'b1);
        pulse(0);
        rd(ttu_pkg::COUNT_H_ADDR, 8'h12);
        rd(ttu_pkg::COUNT_L_ADDR, 8'h34);
        rd(ttu_pkg::CTL_ADDR, 8'h86);
        chk({7'h00, timerIrq}, 8'h01);
        bw(ttu_pkg::OVF_BIT, 1'b0);
        chk({7'h00, timerIrq}, 8'h00);
        // Reload from the control pin, count moved off the reload value first
        wr(ttu_pkg::COUNT_L_ADDR, 8'h00);
        wr(ttu_pkg::CTL_ADDR, 8'h0e);
        pulse(1);
        rd(ttu_pkg::COUNT_L_ADDR, 8'h34);
        rd(ttu_pkg::CTL_ADDR, 8'h4e);
        chk({7'h00, timerIrq}, 8'h01);
        bw(ttu_pkg::EXTF_BIT, 1'b0);
        // Capture leaves the count alone
        wr(ttu_pkg::COUNT_H_ADDR, 8'hab);
        wr(ttu_pkg::COUNT_L_ADDR, 8'hcd);
        wr(ttu_pkg::CTL_ADDR, 8'h0f);
        pulse(1);
        rd(ttu_pkg::RELOAD_H_ADDR, 8'hab);
        rd(ttu_pkg::RELOAD_L_ADDR, 8'hcd);
        rd(ttu_pkg::COUNT_L_ADDR, 8'hcd);
        rd(ttu_pkg::CTL_ADDR, 8'h4f);
        bw(ttu_pkg::EXTF_BIT, 1'b0);
        // Receive clock: pin edge ignored, reload forced, no flag
        wr(ttu_pkg::CTL_ADDR, 8'h2f);
        wr(ttu_pkg::COUNT_L_ADDR, 8'hff);
        wr(ttu_pkg::COUNT_H_ADDR, 8'hff);
        pulse(1);
        rd(ttu_pkg::CTL_ADDR, 8'h2f);
        rd(ttu_pkg::COUNT_L_ADDR, 8'hff);
        r0 = rxCount;
        t0 = txCount;
        pulse(0);
        repeat (57) @(negedge mclk);
        chk(8'(rxCount - r0), 8'h01);
        chk(8'(txCount - t0), 8'h04);
        rd(ttu_pkg::COUNT_H_ADDR, 8'hab);
        rd(ttu_pkg::CTL_ADDR, 8'h2f);
        // Up/down: down to reload, then FFFFh, then up past it
        wr(ttu_pkg::CTL_ADDR, 8'h06);
        wr(ttu_pkg::MODE_ADDR, 8'h01);
        wr(ttu_pkg::RELOAD_H_ADDR, 8'h00);
        wr(ttu_pkg::RELOAD_L_ADDR, 8'h10);
        wr(ttu_pkg::COUNT_H_ADDR, 8'h00);
        wr(ttu_pkg::COUNT_L_ADDR, 8'h11);
        @(negedge mclk) extPin = 1'b0;
        pulse(0);
        rd(ttu_pkg::COUNT_L_ADDR, 8'h10);
        pulse(0);
        rd(ttu_pkg::COUNT_H_ADDR, 8'hff);
        rd(ttu_pkg::CTL_ADDR, 8'hc6);
        bw(ttu_pkg::OVF_BIT, 1'b0);
        chk({7'h00, timerIrq}, 8'h00);
        @(negedge mclk) extPin = 1'b1;
        pulse(0);
        rd(ttu_pkg::COUNT_L_ADDR, 8'h10);
        rd(ttu_pkg::CTL_ADDR, 8'h86);
        chk({7'h00, timerIrq}, 8'h01);
        // Clock out, with the transmit clock sharing the reload pair
        wr(ttu_pkg::CTL_ADDR, 8'h00);
        wr(ttu_pkg::MODE_ADDR, 8'h02);
        wr(ttu_pkg::RELOAD_H_ADDR, 8'hff);
        wr(ttu_pkg::RELOAD_L_ADDR, 8'hfe);
        wr(ttu_pkg::COUNT_H_ADDR, 8'hff);
        wr(ttu_pkg::COUNT_L_ADDR, 8'hfe);
        bw(ttu_pkg::RUN_BIT, 1'b1);
        chk({7'h00, pinOe}, 8'h01);
        waitLvl(1'b0, h);
        waitLvl(1'b1, h);
        waitLvl(1'b0, h);
        chk(8'(h), 8'(HALF));
        waitLvl(1'b1, h);
        chk(8'(h), 8'(HALF));
        rd(ttu_pkg::CTL_ADDR, 8'h04);
        bw(ttu_pkg::TXSEL_BIT, 1'b1);
        t0 = txCount;
        repeat (64) @(negedge mclk);
        chk(8'(txCount - t0), 8'(64 / HALF));
        give_verdict();
    end
endmodule

// ==== testbench/ttu_serial_model.sv ====
// Serial port clock consumer and timer one overflow source
`timescale 1ns/100ps
module ttu_serial_model #(
    parameter int PERIOD = 16
) (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        rxTick,
    input  wire logic        txTick,
    output logic             timerOneOverflow,
    output logic      [15:0] rxCount,
    output logic      [15:0] txCount
);
    int phase;
    // Periodic pulse keeps tick counts exact over any whole number of periods
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase <= 0;
            timerOneOverflow <= 1'b0;
        end
        else
        begin
            phase <= (phase == PERIOD - 1) ? 0 : phase + 1;
            timerOneOverflow <= (phase == PERIOD - 1);
        end
    end
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rxCount <= 16'h0000;
            txCount <= 16'h0000;
        end
        else
        begin
            rxCount <= rxCount + {15'h0000, rxTick};
            txCount <= txCount + {15'h0000, txTick};
        end
    end
endmodule

// ==== verilog/ttu_evt_if.sv ====
// Interface carrying count enables and pin events between input stage and timer core
`timescale 1ns/100ps
interface ttu_evt_if;
    logic run;
    logic counterSel;
    logic clockOutMode;
    logic countTick;
    logic extFall;
    modport src (input run, input counterSel, input clockOutMode, output countTick, output extFall);
    modport dst (output run, output counterSel, output clockOutMode, input countTick, input extFall);
endinterface

// ==== verilog/ttu_input.sv ====
// Input stage: pin edge detection and count-enable generation
`timescale 1ns/100ps
module ttu_input #(
    parameter int DIV = ttu_pkg::CLKOUT_DIV
) (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic countClockPin,
    input  wire logic externalControlPin,
    ttu_evt_if.src    evt
);
    if (DIV != 2)
        $error("ttu_input: only a divide by two is served");

    logic prevCount;
    logic prevExt;
    logic halfPhase;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            prevCount <= 1'b1;
            prevExt   <= 1'b1;
        end
        else
        begin
            prevCount <= countClockPin;
            prevExt   <= externalControlPin;
        end
    end

    // Half-rate enable, reset while stopped so the first tick is predictable
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            halfPhase <= 1'b0;
        else if (!evt.run)
            halfPhase <= 1'b0;
        else
            halfPhase <= ~halfPhase;
    end

    always_comb
    begin
        evt.countTick = 1'b0;
        if (evt.run)
        begin
            if (evt.counterSel)
                evt.countTick = prevCount & ~countClockPin;
            else if (evt.clockOutMode)
                evt.countTick = halfPhase;
            else
                evt.countTick = 1'b1;
        end
    end

    assign evt.extFall = prevExt & ~externalControlPin;
endmodule

// ==== verilog/ttu_pkg.sv ====
// Package with register map, field positions, reset values and modes of the up/down timer
package ttu_pkg;
    // Register offsets in special function register space
    localparam logic [7:0] CTL_ADDR     = 8'hc8;
    localparam logic [7:0] MODE_ADDR    = 8'hc9;
    localparam logic [7:0] RELOAD_L_ADDR = 8'hca;
    localparam logic [7:0] RELOAD_H_ADDR = 8'hcb;
    localparam logic [7:0] COUNT_L_ADDR = 8'hcc;
    localparam logic [7:0] COUNT_H_ADDR = 8'hcd;
    // Control register field positions
    localparam int OVF_BIT   = 7;
    localparam int EXTF_BIT  = 6;
    localparam int RXSEL_BIT = 5;
    localparam int TXSEL_BIT = 4;
    localparam int EXEN_BIT  = 3;
    localparam int RUN_BIT   = 2;
    localparam int CTS_BIT   = 1;
    localparam int CPRL_BIT  = 0;
    // Mode register field positions
    localparam int OE_BIT    = 1;
    localparam int DOWN_COUNT_ENABLE_BIT  = 0;
    // Reset values and top of count
    localparam logic [7:0]  CTL_RESET   = 8'h00;
    localparam logic [1:0]  MODE_RESET  = 2'h0;
    localparam logic [7:0]  BYTE_RESET  = 8'h00;
    localparam logic [15:0] COUNT_TOP   = 16'hffff;
    // Clock-out mode counts at the peripheral clock divided by this
    localparam int CLKOUT_DIV = 2;
    typedef enum logic [1:0] {
        MODE_CAPTURE = 2'b00,
        MODE_RELOAD  = 2'b01,
        MODE_UPDOWN  = 2'b10,
        MODE_BAUD    = 2'b11
    } ttu_mode_type;
endpackage

// ==== verilog/ttu_timer.sv ====
// Timer core: count, reload/capture pair, control and mode registers, clock out
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Function
// - 16-bit count is a low byte carrying into a high byte
// - Select bit clear counts peripheral clock, set counts count-pin falling edges
// - Count advances only while the run bit is set
// - Any serial clock select forces auto-reload, capture/reload bit ignored
// - Reload mode reloads on overflow and on enabled external-pin falling edges
// - Capture mode captures on enabled external-pin falling edges
// - External flag set by pin-caused capture/reload; interrupts only while mode down-count enable is clear; software clears
// - External pin ignored while timer clocks the serial port
// - Up/down, pin high: count up, overflow sets flag and loads reload pair
// - Up/down, pin low: count down, at reload value set flag, load FFFFh
// - Up/down: external flag toggles on each over/underflow, no interrupt
// - Overflow flag set only with both serial selects clear; software clears
// - Receive select routes this overflow as serial receive clock
// - Transmit select routes this overflow as serial transmit clock
// - Clock-out: 50% duty output, reload on overflow, no interrupt
// - Clock-out: count at half peripheral clock
// - Clock-out drives generated clock on the count pin
// - Baud generation and clock out may run together, sharing reload pair
// - Control register resets to zero and is bit addressable
// - Mode output-enable bit makes count pin a clock output
// - Mode down-count enable resets to 0; set enables up/down counting
module ttu_timer (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWr,
    input  wire logic [7:0] sfrWrData,
    input  wire logic       sfrRd,
    output logic      [7:0] sfrRdData,
    input  wire logic       bitWr,
    input  wire logic [7:0] bitAddr,
    input  wire logic       bitVal,
    input  wire logic       countClockPinIn,
    output logic            countClockPinOut,
    output logic            countClockPinOe,
    input  wire logic       externalControlPin,
    input  wire logic       timerOneOverflow,
    output logic            serialRxClockTick,
    output logic            serialTxClockTick,
    output logic            timerIrq
);
    ttu_evt_if evt ();

    logic [7:0] ctl;
    logic [1:0] modeReg;
    logic [7:0] countLow;
    logic [7:0] countHigh;
    logic [7:0] reloadLow;
    logic [7:0] reloadHigh;
    logic       clockOutLevel;
    logic [7:0] next_ctl;
    logic [15:0] next_count;
    logic [15:0] count;
    logic [15:0] reloadPair;

    ttu_pkg::ttu_mode_type mode;
    logic baudUse;
    logic countUp;
    logic overflowUp;
    logic underflow;
    logic overflow;
    logic extEvent;
    logic ctlByteWr;
    logic ctlBitWr;

    ttu_input #(
        .DIV (ttu_pkg::CLKOUT_DIV)
    ) u_input (
        .mclk               (mclk),
        .rstn               (rstn),
        .countClockPin      (countClockPinIn),
        .externalControlPin (externalControlPin),
        .evt                (evt)
    );

    //////////////////////////////////////////////////////////////////////////
    assign count      = {countHigh, countLow};
    assign reloadPair = {reloadHigh, reloadLow};
    assign baudUse    = ctl[ttu_pkg::RXSEL_BIT] | ctl[ttu_pkg::TXSEL_BIT];
    assign evt.run          = ctl[ttu_pkg::RUN_BIT];
    assign evt.counterSel   = ctl[ttu_pkg::CTS_BIT];
    assign evt.clockOutMode = modeReg[ttu_pkg::OE_BIT];

    always_comb
    begin
        if (baudUse)
            mode = ttu_pkg::MODE_BAUD;
        else if (ctl[ttu_pkg::CPRL_BIT])
            mode = ttu_pkg::MODE_CAPTURE;
        else if (modeReg[ttu_pkg::DOWN_COUNT_ENABLE_BIT])
            mode = ttu_pkg::MODE_UPDOWN;
        else
            mode = ttu_pkg::MODE_RELOAD;
    end

    // Direction pin only steers the count in up/down mode
    assign countUp    = (mode != ttu_pkg::MODE_UPDOWN) | externalControlPin;
    assign overflowUp = evt.countTick & countUp & (count == ttu_pkg::COUNT_TOP);
    assign underflow  = evt.countTick & ~countUp & (count == reloadPair);
    assign overflow   = overflowUp | underflow;
    // Pin is a direction input in up/down mode, so its edges do no reload there
    assign extEvent   = evt.extFall & ctl[ttu_pkg::EXEN_BIT]
                        & (mode != ttu_pkg::MODE_BAUD) & (mode != ttu_pkg::MODE_UPDOWN);

    //////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_count = count;
        if (evt.countTick)
        begin
            case (mode)
                ttu_pkg::MODE_UPDOWN:
                begin
                    if (overflowUp)
                        next_count = reloadPair;
                    else if (underflow)
                        next_count = ttu_pkg::COUNT_TOP;
                    else if (countUp)
                        next_count = count + 16'h0001;
                    else
                        next_count = count - 16'h0001;
                end
                ttu_pkg::MODE_CAPTURE:
                begin
                    if (overflowUp && modeReg[ttu_pkg::OE_BIT])
                        next_count = reloadPair;
                    else
                        next_count = count + 16'h0001;
                end
                default:
                begin
                    if (overflowUp)
                        next_count = reloadPair;
                    else
                        next_count = count + 16'h0001;
                end
            endcase
        end
        if (extEvent && mode == ttu_pkg::MODE_RELOAD)
            next_count = reloadPair;
    end

    // Software byte writes win over counting in the same cycle
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            countLow  <= ttu_pkg::BYTE_RESET;
            countHigh <= ttu_pkg::BYTE_RESET;
        end
        else
        begin
            countLow  <= (sfrWr && sfrAddr == ttu_pkg::COUNT_L_ADDR) ? sfrWrData : next_count[7:0];
            countHigh <= (sfrWr && sfrAddr == ttu_pkg::COUNT_H_ADDR) ? sfrWrData : next_count[15:8];
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            reloadLow  <= ttu_pkg::BYTE_RESET;
            reloadHigh <= ttu_pkg::BYTE_RESET;
        end
        else
        begin
            if (sfrWr && sfrAddr == ttu_pkg::RELOAD_L_ADDR)
                reloadLow <= sfrWrData;
            else if (extEvent && mode == ttu_pkg::MODE_CAPTURE)
                reloadLow <= countLow;
            if (sfrWr && sfrAddr == ttu_pkg::RELOAD_H_ADDR)
                reloadHigh <= sfrWrData;
            else if (extEvent && mode == ttu_pkg::MODE_CAPTURE)
                reloadHigh <= countHigh;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    assign ctlByteWr = sfrWr && sfrAddr == ttu_pkg::CTL_ADDR;
    assign ctlBitWr  = bitWr && bitAddr[7:3] == ttu_pkg::CTL_ADDR[7:3];

    always_comb
    begin
        next_ctl = ctl;
        if (ctlByteWr)
            next_ctl = sfrWrData;
        if (ctlBitWr)
            next_ctl[bitAddr[2:0]] = bitVal;
        // Hardware events win over a software clear in the same cycle
        if (overflow && !baudUse && !modeReg[ttu_pkg::OE_BIT])
            next_ctl[ttu_pkg::OVF_BIT] = 1'b1;
        if (overflow && mode == ttu_pkg::MODE_UPDOWN)
            next_ctl[ttu_pkg::EXTF_BIT] = ~ctl[ttu_pkg::EXTF_BIT];
        if (extEvent)
            next_ctl[ttu_pkg::EXTF_BIT] = 1'b1;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            ctl <= ttu_pkg::CTL_RESET;
        else
            ctl <= next_ctl;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            modeReg <= ttu_pkg::MODE_RESET;
        else if (sfrWr && sfrAddr == ttu_pkg::MODE_ADDR)
            modeReg <= sfrWrData[1:0];
    end

    //////////////////////////////////////////////////////////////////////////
    // Toggle per overflow gives half the overflow rate at 50% duty
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            clockOutLevel <= 1'b0;
        else if (!modeReg[ttu_pkg::OE_BIT])
            clockOutLevel <= 1'b0;
        else if (overflowUp)
            clockOutLevel <= ~clockOutLevel;
    end

    assign countClockPinOut = clockOutLevel;
    assign countClockPinOe  = modeReg[ttu_pkg::OE_BIT];

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            serialRxClockTick <= 1'b0;
            serialTxClockTick <= 1'b0;
        end
        else
        begin
            serialRxClockTick <= ctl[ttu_pkg::RXSEL_BIT] ? overflow : timerOneOverflow;
            serialTxClockTick <= ctl[ttu_pkg::TXSEL_BIT] ? overflow : timerOneOverflow;
        end
    end

    // External flag does not interrupt in up/down mode
    assign timerIrq = ctl[ttu_pkg::OVF_BIT]
                      | (ctl[ttu_pkg::EXTF_BIT] & ~modeReg[ttu_pkg::DOWN_COUNT_ENABLE_BIT]);

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            sfrRdData <= 8'h00;
        else if (sfrRd)
        begin
            case (sfrAddr)
                ttu_pkg::CTL_ADDR:      sfrRdData <= ctl;
                ttu_pkg::MODE_ADDR:     sfrRdData <= {6'h00, modeReg};
                ttu_pkg::RELOAD_L_ADDR: sfrRdData <= reloadLow;
                ttu_pkg::RELOAD_H_ADDR: sfrRdData <= reloadHigh;
                ttu_pkg::COUNT_L_ADDR:  sfrRdData <= countLow;
                ttu_pkg::COUNT_H_ADDR:  sfrRdData <= countHigh;
                default:                sfrRdData <= 8'h00;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    logic swCountWr;
    assign swCountWr = sfrWr && (sfrAddr == ttu_pkg::COUNT_L_ADDR || sfrAddr == ttu_pkg::COUNT_H_ADDR);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    ovf_sets_flag_a: assert property (overflow && !baudUse && !modeReg[ttu_pkg::OE_BIT]
        |=> ctl[ttu_pkg::OVF_BIT]) else $error("overflow flag not set");
    flag_only_sw_clear_a: assert property (ctl[ttu_pkg::OVF_BIT] && !ctlByteWr && !ctlBitWr
        |=> ctl[ttu_pkg::OVF_BIT]) else $error("overflow flag cleared by hardware");
    baud_no_flag_a: assert property (!ctl[ttu_pkg::OVF_BIT] && baudUse && !ctlByteWr && !ctlBitWr
        |=> !ctl[ttu_pkg::OVF_BIT]) else $error("overflow flag set in baud mode");
    up_reload_a: assert property (mode == ttu_pkg::MODE_UPDOWN && overflowUp && !swCountWr
        |=> count == $past(reloadPair)) else $error("up overflow did not reload");
    down_top_a: assert property (underflow && !swCountWr
        |=> count == ttu_pkg::COUNT_TOP) else $error("underflow did not load top");
    ud_toggle_a: assert property (mode == ttu_pkg::MODE_UPDOWN && overflow && !ctlByteWr && !ctlBitWr
        |=> ctl[ttu_pkg::EXTF_BIT] != $past(ctl[ttu_pkg::EXTF_BIT])) else $error("no toggle");
    capture_copy_a: assert property (extEvent && mode == ttu_pkg::MODE_CAPTURE && !sfrWr
        |=> reloadPair == $past(count)) else $error("capture value wrong");
    stop_holds_a: assert property (!ctl[ttu_pkg::RUN_BIT] && !swCountWr && !extEvent
        |=> count == $past(count)) else $error("count moved while stopped");
    baud_ignores_pin_a: assert property (baudUse |-> !extEvent)
        else $error("external pin acted in baud mode");
    half_rate_a: assert property (modeReg[ttu_pkg::OE_BIT] && !ctl[ttu_pkg::CTS_BIT] && evt.countTick
        |=> !evt.countTick) else $error("clock-out counts faster than half rate");

    ud_wrap_c: cover property (mode == ttu_pkg::MODE_UPDOWN && underflow);
    ud_up_c:   cover property (mode == ttu_pkg::MODE_UPDOWN && overflowUp);
    capture_c: cover property (extEvent && mode == ttu_pkg::MODE_CAPTURE);
    clkout_c:  cover property (modeReg[ttu_pkg::OE_BIT] && baudUse && overflowUp);
endmodule
